// file: logic/weld_seq_pkg.sv
package weld_seq_pkg;
	// ----------------------------------------
	// Sequence limits
	// ----------------------------------------
	localparam int NUM_STEPS = 5;
	localparam logic [7:0] PROG_MAX = 8'hFA;
	localparam logic [7:0] STEP1_PROG_MIN = 8'h00;
	localparam logic [7:0] STEPN_PROG_MIN = 8'h01;
	localparam logic [7:0] COUNT_MAX = 8'h19;
	localparam logic [7:0] STEP1_COUNT_MIN = 8'h01;
	localparam logic [7:0] STEPN_COUNT_MIN = 8'h00;
	localparam logic [7:0] POS_FIRST = 8'h01;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] STEP1_PROG_RST = 8'h00;
	localparam logic [7:0] STEP1_COUNT_RST = 8'h01;
	localparam logic [7:0] STEPN_PROG_RST = 8'h01;
	localparam logic [7:0] STEPN_COUNT_RST = 8'h00;

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] STEP_BASE = 8'h00; // Program at +8*i, count at +8*i+4
	localparam logic [7:0] STEP_STRIDE = 8'h08;
	localparam logic [7:0] STEP_LAST = 8'h24;
	localparam logic [7:0] CTRL_OFS = 8'h28;
	localparam logic [7:0] STATUS_OFS = 8'h2C;
	localparam logic [7:0] LAST_POS_OFS = 8'h30;
	localparam logic [7:0] TOTAL_OFS = 8'h34;
	localparam logic [7:0] NEXT_POS_OFS = 8'h38;
	localparam logic [7:0] NEXT_PROG_OFS = 8'h3C;
	localparam logic [7:0] LAST_PROG_OFS = 8'h40;
	localparam logic [7:0] LAST_RMS_OFS = 8'h44;
	localparam logic [7:0] LAST_TIME_OFS = 8'h48;
	localparam logic [7:0] SPOT_CNT_OFS = 8'h4C;

	// Field positions
	localparam int CTRL_REWIND_BIT = 0;
	localparam int STATUS_ACTIVE_BIT = 0;
	localparam int STATUS_BUSY_BIT = 1;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Result of one spot from the weld timer
	typedef struct packed {
		logic [15:0] rms;
		logic [15:0] weld_time;
	} spot_result_s;

	// Write command from the bus slave
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [31:0] data;
	} reg_write_s;

	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_WELD = 1'b1
	} seq_state_e;
endpackage

// file: logic/axil_slave_port.sv
`timescale 1ns/100ps
module axil_slave_port (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output weld_seq_pkg::reg_write_s wr,
	input wire logic wr_err,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);
	import weld_seq_pkg::*;

	logic aw_held, w_held;
	logic aw_err, next_aw_err;
	logic next_aw_held, next_w_held, next_awready, next_wready, next_bvalid;
	logic next_arready, next_rvalid;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	reg_write_s next_wr;

	assign rd_addr = araddr;

	// ----------------------------------------
	// Handshakes
	// ----------------------------------------
	// Address and data may arrive in either order; the write fires once both are held
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_aw_err = aw_err;
		next_w_data = w_data;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_wr = '0;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = awaddr;
			// Judged on the address as taken; the master may move it afterwards
			next_aw_err = wr_err;
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			next_w_data = wdata;
		end
		if (bvalid && bready)
			next_bvalid = 1'b0;
		if (aw_held && w_held && !bvalid) begin
			next_wr.en = 1'b1;
			next_wr.addr = aw_addr;
			next_wr.data = w_data;
			next_bresp = aw_err ? RESP_SLVERR : RESP_OKAY;
			next_bvalid = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
		end
		// Ready drops while a word is held, so one write at most is in flight
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && rready)
			next_rvalid = 1'b0;
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rdata = rd_data;
			next_rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			aw_err <= 1'b0;
			w_data <= '0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
			wr <= '0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			aw_err <= next_aw_err;
			w_data <= next_w_data;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			wr <= next_wr;
		end
	end
endmodule

// file: logic/weld_program_sequencer.sv
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - Five steps of program and spot count; step one takes program 0-250, count 1-25.
// - Steps two to five take program 1-250 and count 0-25.
// - Step one program zero disables the sequence; no automatic program choice.
// - With the sequence active, the external program selection is ignored.
// - One cycle start per spot; each start taken while idle makes exactly one spot, a start while a spot runs is ignored.
// - After a step's spot count, move to the next step and its program.
// - Report last completed spot position and sequence total, the sum of counts.
// - Report next spot position and the program it will use.
// - After each spot report program used and measured RMS current.
// - After each spot report weld time and cumulative spot counter.
// - In run position, forward key moves next position up by one.
// - In run position, backward key moves next position back by one.
module weld_program_sequencer #(
	parameter int STEPS = weld_seq_pkg::NUM_STEPS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cycle_start,
	input wire logic key_run,
	input wire logic key_forward,
	input wire logic key_backward,
	input wire logic [7:0] ext_program,
	output logic weld_go,
	output logic [7:0] weld_program,
	input wire logic weld_done,
	input wire weld_seq_pkg::spot_result_s weld_result,
	output logic program_sequence_mode,
	output logic [7:0] next_program_indicator
);
	import weld_seq_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Program for a 1-based spot position; zero-count steps never match
	function automatic logic [7:0] prog_at(input logic [7:0] pos,
			input logic [STEPS-1:0][7:0] prg, input logic [STEPS-1:0][7:0] cnt);
		logic [7:0] acc;
		logic [7:0] res;
		logic hit;
		acc = '0;
		res = prg[0];
		hit = 1'b0;
		for (int i = 0; i < STEPS; i++) begin
			acc = acc + cnt[i];
			if (!hit && pos <= acc && cnt[i] != 8'h00) begin
				res = prg[i];
				hit = 1'b1;
			end
		end
		return res;
	endfunction

	// Range check on a written value for a given step
	function automatic logic value_ok(input int step, input logic is_count,
			input logic [7:0] v);
		logic [7:0] lo;
		if (is_count)
			lo = (step == 0) ? STEP1_COUNT_MIN : STEPN_COUNT_MIN;
		else
			lo = (step == 0) ? STEP1_PROG_MIN : STEPN_PROG_MIN;
		return v >= lo && v <= (is_count ? COUNT_MAX : PROG_MAX);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [STEPS-1:0][7:0] step_program_number, next_step_program_number;
	logic [STEPS-1:0][7:0] step_count, next_step_count;
	logic [2:0] start_sync, key_fwd_sync, key_back_sync, next_start_sync;
	logic [2:0] next_key_fwd_sync, next_key_back_sync;
	logic [1:0] run_sync, next_run_sync;
	seq_state_e state, next_state;
	logic [7:0] last_pos, next_last_pos, next_pos, next_next_pos;
	logic [7:0] last_prog, next_last_prog;
	spot_result_s last_result, next_last_result;
	logic [31:0] spot_cnt, next_spot_cnt;
	logic next_weld_go;
	logic [7:0] next_weld_program;
	logic next_mode;
	logic [7:0] next_indicator;
	logic [7:0] total;
	logic seq_active;
	logic start_edge, fwd_edge, back_edge;
	reg_write_s wr;
	logic wr_err;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	axil_slave_port u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr(wr),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// Writes beyond the step table and control word are refused
	assign wr_err = !(s_axi_awaddr <= STEP_LAST || s_axi_awaddr == CTRL_OFS) ||
		s_axi_awaddr[1:0] != 2'b00;

	// Derived sequence figures
	always_comb begin
		total = '0;
		for (int i = 0; i < STEPS; i++)
			total = total + step_count[i];
	end
	// Step one program zero turns the whole sequence off
	assign seq_active = step_program_number[0] != 8'h00;
	// Edge detect on the second stage only, never on the first flop
	assign start_edge = start_sync[1] && !start_sync[2];
	assign fwd_edge = key_fwd_sync[1] && !key_fwd_sync[2];
	assign back_edge = key_back_sync[1] && !key_back_sync[2];

	// Read mux; status and progress are live
	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		if (rd_addr <= STEP_LAST && rd_addr[1:0] == 2'b00) begin
			for (int i = 0; i < STEPS; i++) begin
				if (rd_addr == STEP_BASE + 8'(i) * STEP_STRIDE)
					rd_data[7:0] = step_program_number[i];
				if (rd_addr == STEP_BASE + 8'(i) * STEP_STRIDE + 8'h04)
					rd_data[7:0] = step_count[i];
			end
		end else begin
			case (rd_addr)
				CTRL_OFS: rd_data = '0;
				STATUS_OFS: begin
					rd_data[STATUS_ACTIVE_BIT] = seq_active;
					rd_data[STATUS_BUSY_BIT] = state == SEQ_WELD;
				end
				LAST_POS_OFS: rd_data[7:0] = last_pos;
				TOTAL_OFS: rd_data[7:0] = total;
				NEXT_POS_OFS: rd_data[7:0] = next_pos;
				NEXT_PROG_OFS: rd_data[7:0] = next_program_indicator;
				LAST_PROG_OFS: rd_data[7:0] = last_prog;
				LAST_RMS_OFS: rd_data[15:0] = last_result.rms;
				LAST_TIME_OFS: rd_data[15:0] = last_result.weld_time;
				SPOT_CNT_OFS: rd_data = spot_cnt;
				default: rd_err = 1'b1;
			endcase
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Pins pass two flops; a third holds the previous level for edges
	always_comb begin
		next_start_sync = {start_sync[1:0], cycle_start};
		next_key_fwd_sync = {key_fwd_sync[1:0], key_forward};
		next_key_back_sync = {key_back_sync[1:0], key_backward};
		next_run_sync = {run_sync[0], key_run};
		next_step_program_number = step_program_number;
		next_step_count = step_count;
		next_state = state;
		next_last_pos = last_pos;
		next_next_pos = next_pos;
		next_last_prog = last_prog;
		next_last_result = last_result;
		next_spot_cnt = spot_cnt;
		next_weld_go = 1'b0;
		next_weld_program = weld_program;
		// Out-of-range values are dropped so the table stays legal
		if (wr.en) begin
			for (int i = 0; i < STEPS; i++) begin
				if (wr.addr == STEP_BASE + 8'(i) * STEP_STRIDE &&
						wr.data[31:8] == '0 && value_ok(i, 1'b0, wr.data[7:0]))
					next_step_program_number[i] = wr.data[7:0];
				if (wr.addr == STEP_BASE + 8'(i) * STEP_STRIDE + 8'h04 &&
						wr.data[31:8] == '0 && value_ok(i, 1'b1, wr.data[7:0]))
					next_step_count[i] = wr.data[7:0];
			end
			if (wr.addr == CTRL_OFS && wr.data[CTRL_REWIND_BIT])
				next_next_pos = POS_FIRST;
		end
		case (state)
			SEQ_IDLE: begin
				if (start_edge) begin
					next_weld_go = 1'b1;
					// External choice only counts while the sequence is off
					next_weld_program = seq_active ? next_program_indicator :
						ext_program;
					next_state = SEQ_WELD;
				end else if (run_sync[1] && seq_active) begin
					// Keys act between spots only, never in the cycle of a start
					if (fwd_edge && next_pos < total)
						next_next_pos = next_pos + 8'h01;
					else if (back_edge && next_pos > POS_FIRST)
						next_next_pos = next_pos - 8'h01;
				end
			end
			SEQ_WELD: begin
				// Further starts are ignored until the spot reports back
				if (weld_done) begin
					next_last_prog = weld_program;
					next_last_result = weld_result;
					next_spot_cnt = spot_cnt + 32'h1;
					// Disabled mode still counts spots but leaves the position alone
					if (seq_active) begin
						next_last_pos = next_pos;
						next_next_pos = (next_pos >= total) ? POS_FIRST : next_pos + 8'h01;
					end
					next_state = SEQ_IDLE;
				end
			end
			default: next_state = SEQ_IDLE;
		endcase
		// A shrunken table must not leave the pointer past its end
		if (next_next_pos > total || next_next_pos < POS_FIRST)
			next_next_pos = POS_FIRST;
		next_mode = seq_active;
		next_indicator = prog_at(next_next_pos, next_step_program_number,
			next_step_count);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_sync <= '0;
			key_fwd_sync <= '0;
			key_back_sync <= '0;
			run_sync <= '0;
			step_program_number[0] <= STEP1_PROG_RST;
			step_count[0] <= STEP1_COUNT_RST;
			for (int i = 1; i < STEPS; i++) begin
				step_program_number[i] <= STEPN_PROG_RST;
				step_count[i] <= STEPN_COUNT_RST;
			end
			state <= SEQ_IDLE;
			last_pos <= '0;
			next_pos <= POS_FIRST;
			last_prog <= '0;
			last_result <= '0;
			spot_cnt <= '0;
			weld_go <= 1'b0;
			weld_program <= '0;
			program_sequence_mode <= 1'b0;
			next_program_indicator <= STEP1_PROG_RST;
		end else begin
			start_sync <= next_start_sync;
			key_fwd_sync <= next_key_fwd_sync;
			key_back_sync <= next_key_back_sync;
			run_sync <= next_run_sync;
			step_program_number <= next_step_program_number;
			step_count <= next_step_count;
			state <= next_state;
			last_pos <= next_last_pos;
			next_pos <= next_next_pos;
			last_prog <= next_last_prog;
			last_result <= next_last_result;
			spot_cnt <= next_spot_cnt;
			weld_go <= next_weld_go;
			weld_program <= next_weld_program;
			program_sequence_mode <= next_mode;
			next_program_indicator <= next_indicator;
		end
	end
endmodule

// file: sim/weld_seq_checker.sv
`timescale 1ns/100ps
module weld_seq_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic cycle_start,
	input wire logic [7:0] ext_program,
	input wire logic weld_go,
	input wire logic [7:0] weld_program,
	input wire logic program_sequence_mode,
	input wire logic [7:0] next_program_indicator
);
	import weld_seq_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ------
	// Spot link
	// ------
	property p_go_pulse;
		weld_go |=> !weld_go;
	endproperty
	a_go_pulse: assert property (p_go_pulse)
		else $error("weld_go too long");
	// Two sync stages and the go register sit between the pin and the go pulse
	property p_go_cause;
		weld_go |-> $past(cycle_start, 2);
	endproperty
	a_go_cause: assert property (p_go_cause)
		else $error("weld_go without start");
	property p_prog_stands;
		!weld_go |-> $stable(weld_program);
	endproperty
	a_prog_stands: assert property (p_prog_stands)
		else $error("weld_program moved between spots");
	property p_seq_prog;
		weld_go && program_sequence_mode |-> weld_program == $past(next_program_indicator);
	endproperty
	a_seq_prog: assert property (p_seq_prog)
		else $error("spot not using announced program");
	property p_ext_prog;
		weld_go && !program_sequence_mode |-> weld_program == $past(ext_program);
	endproperty
	a_ext_prog: assert property (p_ext_prog)
		else $error("disabled mode ignored external program");
	// ------
	// Register bus
	// ------
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write response missing");
	property p_b_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_block: assert property (p_b_block)
		else $error("new write taken before response");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read response late");
	c_seq: cover property (weld_go && program_sequence_mode);
	c_ext: cover property (weld_go && !program_sequence_mode);
	c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind weld_program_sequencer weld_seq_checker chk_u (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .cycle_start, .ext_program, .weld_go,
	.weld_program, .program_sequence_mode, .next_program_indicator);

// file: sim/weld_partner.sv
`timescale 1ns/100ps
module weld_partner (
	input wire logic aclk,
	input wire logic [3:0] lag,
	input wire logic weld_go,
	input wire logic [7:0] weld_program,
	output logic weld_done,
	output weld_seq_pkg::spot_result_s weld_result,
	output logic cycle_start,
	output logic key_forward,
	output logic key_backward
);
	import weld_seq_pkg::*;
	logic [2:0] pins = 3'h0;
	logic [3:0] left = 4'h0;
	logic busy = 1'b0;
	initial weld_done = 1'b0;
	initial weld_result = 32'h0;
	assign {key_backward, key_forward, cycle_start} = pins;
	// ------
	// Weld timer
	// ------
	// Done only after a go; result toggles while no spot runs
	always @(posedge aclk) begin
		weld_done <= 1'b0;
		if (weld_go === 1'b1) begin
			busy <= 1'b1;
			left <= lag;
		end else if (busy && left != 4'h0) begin
			left <= left - 4'h1;
		end else if (busy) begin
			busy <= 1'b0;
			weld_done <= 1'b1;
			weld_result <= {8'hA5, weld_program, 8'h3C, weld_program};
		end else begin
			weld_result <= ~weld_result;
		end
	end
	// One start or key press, held past the sync stages
	task automatic request(input int which);
		@(posedge aclk);
		pins[which] <= 1'b1;
		repeat (4) @(posedge aclk);
		pins[which] <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
	import weld_seq_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext_program = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, key_run = 1'b0;
	logic [3:0] lag = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic cycle_start, key_forward, key_backward, weld_go, weld_done;
	logic program_sequence_mode;
	logic [7:0] weld_program, next_program_indicator;
	spot_result_s weld_result;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	int sp [4] = '{3, 7, 11, 4};
	int sc [4] = '{4, 2, 6, 1};
	weld_program_sequencer dut_u (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cycle_start, .key_run, .key_forward,
		.key_backward, .ext_program, .weld_go, .weld_program, .weld_done, .weld_result,
		.program_sequence_mode, .next_program_indicator
	);
	weld_partner partner_u (
		.aclk, .lag, .weld_go, .weld_program, .weld_done, .weld_result, .cycle_start,
		.key_forward, .key_backward
	);
	// ------
	// Clock, watchdog and helpers
	// ------
	always #5 aclk = ~aclk;
	// Whole run needs under a thousand cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check(what, s_axi_rdata, ed);
		check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	function automatic logic [7:0] prog_at(input int p);
		for (int s = 0; s < 4; s++) begin
			if (p <= sc[s]) return 8'(sp[s]);
			p -= sc[s];
		end
		return 8'h00;
	endfunction
	// One spot and its reported results
	task automatic spot(input logic [7:0] ep, input logic [31:0] cnt);
		fork
			partner_u.request(0);
			begin
				do @(posedge aclk); while (weld_go !== 1'b1);
				check("weld_program", {24'h0, weld_program}, {24'h0, ep});
				do @(posedge aclk); while (weld_done !== 1'b1);
			end
		join
		rd("last_prog", LAST_PROG_OFS, {24'h0, ep});
		rd("last_rms", LAST_RMS_OFS, {16'h0, 8'hA5, ep});
		rd("weld_time", LAST_TIME_OFS, {16'h0, 8'h3C, ep});
		rd("spot_count", SPOT_CNT_OFS, cnt);
	endtask
	// ------
	// Scenarios
	// ------
	task automatic t_regs();
		logic [7:0] ta [6] = '{8'h00, 8'h04, 8'h0C, 8'h08, 8'h08, 8'h0C};
		logic [7:0] td [6] = '{8'hFB, 8'h00, 8'h1A, 8'h00, 8'hFA, 8'h19};
		logic [7:0] te [6] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'hFA, 8'h19};
		for (int i = 0; i < 5; i++) begin
			rd("step_prog", 8'(8 * i), {24'h0, i ? STEPN_PROG_RST : STEP1_PROG_RST});
			rd("step_count", 8'(8 * i + 4), {24'h0, i ? STEPN_COUNT_RST : STEP1_COUNT_RST});
		end
		rd("unmapped", 8'h50, 32'h0, RESP_SLVERR);
		wr(8'h50, 32'h1, RESP_SLVERR);
		// Out-of-range values are dropped, edges of the range kept
		for (int i = 0; i < 6; i++) begin
			wr(ta[i], {24'h0, td[i]}, RESP_OKAY);
			rd("step_edit", ta[i], {24'h0, te[i]});
		end
		rd("total", TOTAL_OFS, 32'd26);
		check("mode", {31'h0, program_sequence_mode}, 32'h0);
	endtask
	task automatic t_disabled();
		ext_program <= 8'h2A;
		spot(8'h2A, 32'h1);
		rd("next_pos", NEXT_POS_OFS, 32'h1);
	endtask
	task automatic t_seq();
		int p;
		ext_program <= 8'hC8;
		for (int i = 0; i < 4; i++) begin
			wr(8'(8 * i), 32'(sp[i]), RESP_OKAY);
			wr(8'(8 * i + 4), 32'(sc[i]), RESP_OKAY);
		end
		wr(8'h24, 32'h0, RESP_OKAY);
		rd("total", TOTAL_OFS, 32'd13);
		check("mode", {31'h0, program_sequence_mode}, 32'h1);
		for (int n = 0; n < 14; n++) begin
			lag <= 4'(3 * (n % 3));
			p = n % 13 + 1;
			rd("next_prog", NEXT_PROG_OFS, {24'h0, prog_at(p)});
			spot(prog_at(p), 32'(n + 2));
			rd("last_pos", LAST_POS_OFS, 32'(p));
			rd("next_pos", NEXT_POS_OFS, 32'(p % 13 + 1));
		end
	endtask
	task automatic t_keys();
		partner_u.request(1);
		rd("next_pos", NEXT_POS_OFS, 32'h2);
		key_run <= 1'b1;
		partner_u.request(1);
		rd("next_pos", NEXT_POS_OFS, 32'h3);
		repeat (3) partner_u.request(2);
		rd("next_pos", NEXT_POS_OFS, 32'h1);
		repeat (13) partner_u.request(1);
		rd("next_pos", NEXT_POS_OFS, 32'd13);
		check("indicator", {24'h0, next_program_indicator}, 32'h4);
		spot(8'h04, 32'd16);
		rd("next_pos", NEXT_POS_OFS, 32'h1);
		// Rewind through the control word, then the live status words
		partner_u.request(1);
		rd("next_pos", NEXT_POS_OFS, 32'h2);
		wr(CTRL_OFS, 32'h1, RESP_OKAY);
		rd("rewind", NEXT_POS_OFS, 32'h1);
		rd("indicator", NEXT_PROG_OFS, 32'h3);
		rd("status", STATUS_OFS, 32'h1);
		rd("ctrl", CTRL_OFS, 32'h0);
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_disabled();
		t_seq();
		t_keys();
		report_and_stop();
	end
endmodule
